// File: common/cmtd_consts.svh
/*
 Constants for the compare/move/touch decoder: opcode fields, codes, sizes.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef CMTD_CONSTS_SVH
`define CMTD_CONSTS_SVH

`define CMTD_OP_CMP 4'hB
`define CMTD_OP_COMPARE_WITH_IMMEDIATE_HI 8'h0C
`define CMTD_OP_TOUCH_HI 13'h1E85
`define CMTD_SEL_CMP_B 3'h0
`define CMTD_SEL_CMP_W 3'h1
`define CMTD_SEL_CMP_L 3'h2
`define CMTD_SEL_COMPARE_ADDRESS_REGISTER_W 3'h3
`define CMTD_SEL_COMPARE_ADDRESS_REGISTER_L 3'h7
`define CMTD_ISZ_B 2'h0
`define CMTD_ISZ_W 2'h1
`define CMTD_ISZ_L 2'h2
`define CMTD_MSZ_B 2'h1
`define CMTD_MSZ_W 2'h3
`define CMTD_MSZ_L 2'h2
`define CMTD_M_DREG 3'h0
`define CMTD_M_AREG 3'h1
`define CMTD_M_IND 3'h2
`define CMTD_M_POST 3'h3
`define CMTD_M_PRE 3'h4
`define CMTD_M_D16 3'h5
`define CMTD_M_IDX 3'h6
`define CMTD_M_EXT 3'h7
`define CMTD_R_ABSW 3'h0
`define CMTD_R_ABSL 3'h1
`define CMTD_R_PCD 3'h2
`define CMTD_R_PCX 3'h3
`define CMTD_R_IMM 3'h4
`define CMTD_LINE_BYTES 5'h10
`define CMTD_LOCK_BIT 11

`endif

// File: common/cmtd_pkg.sv
/*
 Types for the compare/move/touch decoder.
 Assumes cmtd_consts.svh sits on the include path.
*/
package cmtd_pkg;
    `include "cmtd_consts.svh"

    typedef enum logic [1:0] {
        CMTD_SZ_B = 2'h0,
        CMTD_SZ_W = 2'h1,
        CMTD_SZ_L = 2'h2
    } cmtd_size_t;

    typedef enum logic [2:0] {
        CMTD_ST_IDLE = 3'h0,
        CMTD_ST_EXT1 = 3'h1,
        CMTD_ST_EXT2 = 3'h3,
        CMTD_ST_EXEC = 3'h2,
        CMTD_ST_FILL = 3'h6
    } cmtd_state_t;

    typedef enum logic [2:0] {
        CMTD_K_NONE = 3'h0,
        CMTD_K_CMP = 3'h1,
        CMTD_K_COMPARE_ADDRESS_REGISTER = 3'h2,
        CMTD_K_COMPARE_WITH_IMMEDIATE = 3'h3,
        CMTD_K_TOUCH = 3'h4,
        CMTD_K_MOVE = 3'h5,
        CMTD_K_MOVE_TO_ADDRESS_REGISTER = 3'h6
    } cmtd_kind_t;

    // N Z V C, extend kept outside
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } cmtd_cc_t;

    typedef struct packed {
        cmtd_kind_t kind;
        cmtd_size_t size;
        logic [2:0] dst_reg;
        logic [2:0] dst_mode;
        logic [2:0] src_mode;
        logic [2:0] src_reg;
        logic illegal;
    } cmtd_dec_t;
endpackage : cmtd_pkg

// File: core/cmtd_ea_check.sv
/*
 Effective-address legality check for one mode/register pair.
 Assumes a purely combinational use by the decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module cmtd_ea_check (
    input wire logic [2:0] i_mode,
    input wire logic [2:0] i_reg,
    input wire logic i_as_dest,
    output logic o_ok,
    output logic o_far
);
    `include "cmtd_consts.svh"
    always_comb begin
        o_ok = 1'b0;
        o_far = 1'b0;
        case (i_mode)
            `CMTD_M_EXT: begin
                case (i_reg)
                    `CMTD_R_ABSW, `CMTD_R_ABSL: begin
                        o_ok = 1'b1;
                        o_far = 1'b1;
                    end
                    `CMTD_R_IMM, `CMTD_R_PCD, `CMTD_R_PCX: begin
                        // PC relative and immediate cannot be written
                        o_ok = !i_as_dest;
                        o_far = 1'b1;
                    end
                    default: o_ok = 1'b0;
                endcase
            end
            `CMTD_M_AREG: o_ok = !i_as_dest;
            `CMTD_M_D16, `CMTD_M_IDX: begin
                o_ok = 1'b1;
                o_far = 1'b1;
            end
            default: o_ok = 1'b1;
        endcase
    end
endmodule : cmtd_ea_check
`default_nettype wire

// File: core/cmtd_flags.sv
/*
 Sized subtract producing compare condition codes.
 Assumes operands already sign-extended or sized by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module cmtd_flags (
    input wire logic [31:0] i_dst,
    input wire logic [31:0] i_src,
    input wire cmtd_pkg::cmtd_size_t i_size,
    output cmtd_pkg::cmtd_cc_t o_cc
);
    import cmtd_pkg::*;
    logic [32:0] diff;
    logic sd;
    logic ss;
    logic sr;
    logic zero;
    logic brw;
    always_comb begin
        diff = {1'b0, i_dst} - {1'b0, i_src};
        case (i_size)
            CMTD_SZ_B: begin
                sd = i_dst[7];
                ss = i_src[7];
                sr = diff[7];
                zero = (diff[7:0] == 8'h00);
                brw = (i_dst[7:0] < i_src[7:0]);
            end
            CMTD_SZ_W: begin
                sd = i_dst[15];
                ss = i_src[15];
                sr = diff[15];
                zero = (diff[15:0] == 16'h0000);
                brw = (i_dst[15:0] < i_src[15:0]);
            end
            default: begin
                sd = i_dst[31];
                ss = i_src[31];
                sr = diff[31];
                zero = (diff[31:0] == 32'h0000_0000);
                brw = diff[32];
            end
        endcase
        o_cc.n = sr;
        o_cc.z = zero;
        o_cc.v = (sd != ss) && (sr != sd);
        o_cc.c = brw;
    end
endmodule : cmtd_flags
`default_nettype wire

// File: core/cmtd_decoder.sv
/*
 Decoder and executor for compare, compare-address, compare-immediate,
 fetch touch, general move and address move. Assumes the core supplies
 opcode words with a valid strobe, register operand values and the
 moved value, and takes the decoded result and cache requests.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Data compare fields and byte/word/long selectors
// - Compare sets NZVC, register unchanged
// - Address-register source only word/long compares
// - Address compare sign-extends word source
// - Immediate compare size field, register bits 2-0
// - Immediate from extension words, upper first
// - Fetch touch supervisor only, else trap
// - Cacheable touch loads 16-byte line
// - Lock bit locks touched lines; CC kept
// - General move size codes and fields
// - Move sets NZ, clears VC, extend kept
// - Source modes decoded incl. extended forms
// - Move destination data-alterable only
// - Far sources exclude indexed/absolute destinations
// - Immediate to d16 destination byte/word only
// - Address move destination 001, CC kept
module cmtd_decoder (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_word_valid,
    input wire logic [15:0] i_word,
    input wire logic i_supervisor,
    input wire logic [31:0] i_dreg_value,
    input wire logic [31:0] i_areg_value,
    input wire logic [31:0] i_src_value,
    input wire logic i_cacheable,
    input wire logic [31:0] i_cache_ctrl,
    input wire logic i_fill_done,
    output logic o_busy,
    output cmtd_pkg::cmtd_dec_t o_dec,
    output logic o_done,
    output logic o_cc_we,
    output cmtd_pkg::cmtd_cc_t o_cc,
    output logic o_illegal,
    output logic o_priv_trap,
    output logic o_fill_req,
    output logic [31:0] o_fill_addr,
    output logic [4:0] o_fill_bytes,
    output logic o_fill_lock
);
    import cmtd_pkg::*;
    `include "cmtd_consts.svh"

    cmtd_state_t state_q;
    cmtd_dec_t dec_q;
    cmtd_dec_t dec_d;
    logic [31:0] imm_q;
    logic [2:0] sel;
    logic src_ok;
    logic src_far;
    logic dst_ok;
    logic dst_far;
    logic [31:0] cmp_dst;
    logic [31:0] cmp_src;
    cmtd_cc_t sub_cc;
    cmtd_cc_t move_cc;

    assign sel = i_word[8:6];

    cmtd_ea_check u_src (
        .i_mode(i_word[5:3]),
        .i_reg(i_word[2:0]),
        .i_as_dest(1'b0),
        .o_ok(src_ok),
        .o_far(src_far)
    );

    cmtd_ea_check u_dst (
        .i_mode(i_word[8:6]),
        .i_reg(i_word[11:9]),
        .i_as_dest(1'b1),
        .o_ok(dst_ok),
        .o_far(dst_far)
    );

    always_comb begin
        dec_d = '0;
        dec_d.dst_reg = i_word[11:9];
        dec_d.dst_mode = i_word[8:6];
        dec_d.src_mode = i_word[5:3];
        dec_d.src_reg = i_word[2:0];
        if (i_word[15:12] == `CMTD_OP_CMP) begin
            case (sel)
                `CMTD_SEL_CMP_B: dec_d.size = CMTD_SZ_B;
                `CMTD_SEL_CMP_W, `CMTD_SEL_COMPARE_ADDRESS_REGISTER_W: dec_d.size = CMTD_SZ_W;
                default: dec_d.size = CMTD_SZ_L;
            endcase
            if (sel == `CMTD_SEL_COMPARE_ADDRESS_REGISTER_W || sel == `CMTD_SEL_COMPARE_ADDRESS_REGISTER_L) begin
                dec_d.kind = CMTD_K_COMPARE_ADDRESS_REGISTER;
            end else begin
                dec_d.kind = CMTD_K_CMP;
            end
            dec_d.illegal = !src_ok ||
                !(sel == `CMTD_SEL_CMP_B || sel == `CMTD_SEL_CMP_W ||
                  sel == `CMTD_SEL_CMP_L || sel == `CMTD_SEL_COMPARE_ADDRESS_REGISTER_W ||
                  sel == `CMTD_SEL_COMPARE_ADDRESS_REGISTER_L);
            // no byte compare of an address register
            if (i_word[5:3] == `CMTD_M_AREG && sel == `CMTD_SEL_CMP_B) begin
                dec_d.illegal = 1'b1;
            end
        end else if (i_word[15:8] == `CMTD_OP_COMPARE_WITH_IMMEDIATE_HI && i_word[5:3] == 3'h0) begin
            dec_d.kind = CMTD_K_COMPARE_WITH_IMMEDIATE;
            dec_d.dst_reg = i_word[2:0];
            case (i_word[7:6])
                `CMTD_ISZ_B: dec_d.size = CMTD_SZ_B;
                `CMTD_ISZ_W: dec_d.size = CMTD_SZ_W;
                `CMTD_ISZ_L: dec_d.size = CMTD_SZ_L;
                default: dec_d.illegal = 1'b1;
            endcase
        end else if (i_word[15:3] == `CMTD_OP_TOUCH_HI) begin
            dec_d.kind = CMTD_K_TOUCH;
            dec_d.size = CMTD_SZ_L;
        end else if (i_word[15:14] == 2'h0 && i_word[13:12] != 2'h0) begin
            case (i_word[13:12])
                `CMTD_MSZ_B: dec_d.size = CMTD_SZ_B;
                `CMTD_MSZ_W: dec_d.size = CMTD_SZ_W;
                default: dec_d.size = CMTD_SZ_L;
            endcase
            if (i_word[8:6] == `CMTD_M_AREG) begin
                // address move, word or long only
                dec_d.kind = CMTD_K_MOVE_TO_ADDRESS_REGISTER;
                dec_d.illegal = !src_ok || (i_word[13:12] == `CMTD_MSZ_B);
            end else begin
                dec_d.kind = CMTD_K_MOVE;
                dec_d.illegal = !src_ok || !dst_ok;
                if (src_far && dst_far && i_word[8:6] != `CMTD_M_D16) begin
                    dec_d.illegal = 1'b1;
                end
                if (i_word[5:0] == {`CMTD_M_EXT, `CMTD_R_IMM} &&
                    i_word[8:6] == `CMTD_M_D16 && i_word[13:12] == `CMTD_MSZ_L) begin
                    dec_d.illegal = 1'b1;
                end
            end
        end else begin
            // Words outside these groups leave the decoder idle
            dec_d.kind = CMTD_K_NONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= CMTD_ST_IDLE;
        end else begin
            case (state_q)
                CMTD_ST_IDLE: begin
                    if (i_word_valid) begin
                        if (dec_d.kind == CMTD_K_COMPARE_WITH_IMMEDIATE && !dec_d.illegal) begin
                            state_q <= CMTD_ST_EXT1;
                        end else if (dec_d.kind != CMTD_K_NONE) begin
                            state_q <= CMTD_ST_EXEC;
                        end
                    end
                end
                CMTD_ST_EXT1: begin
                    if (i_word_valid) begin
                        if (dec_q.size == CMTD_SZ_L) begin
                            state_q <= CMTD_ST_EXT2;
                        end else begin
                            state_q <= CMTD_ST_EXEC;
                        end
                    end
                end
                CMTD_ST_EXT2: begin
                    if (i_word_valid) begin
                        state_q <= CMTD_ST_EXEC;
                    end
                end
                CMTD_ST_EXEC: begin
                    if (dec_q.kind == CMTD_K_TOUCH && !dec_q.illegal &&
                        i_supervisor && i_cacheable) begin
                        state_q <= CMTD_ST_FILL;
                    end else begin
                        state_q <= CMTD_ST_IDLE;
                    end
                end
                CMTD_ST_FILL: begin
                    if (i_fill_done) begin
                        state_q <= CMTD_ST_IDLE;
                    end
                end
                default: state_q <= CMTD_ST_IDLE;
            endcase
        end
    end

    // word source sign-extended for address compare
    always_comb begin
        cmp_dst = i_dreg_value;
        cmp_src = i_src_value;
        if (dec_q.kind == CMTD_K_COMPARE_ADDRESS_REGISTER) begin
            cmp_dst = i_areg_value;
            if (dec_q.size == CMTD_SZ_W) begin
                cmp_src = {{16{i_src_value[15]}}, i_src_value[15:0]};
            end
        end else if (dec_q.kind == CMTD_K_COMPARE_WITH_IMMEDIATE) begin
            cmp_src = imm_q;
        end
    end

    cmtd_flags u_sub (
        .i_dst(cmp_dst),
        .i_src(cmp_src),
        .i_size((dec_q.kind == CMTD_K_COMPARE_ADDRESS_REGISTER) ? CMTD_SZ_L : dec_q.size),
        .o_cc(sub_cc)
    );

    // NZ from moved value, VC cleared
    always_comb begin
        move_cc.v = 1'b0;
        move_cc.c = 1'b0;
        case (dec_q.size)
            CMTD_SZ_B: begin
                move_cc.n = i_src_value[7];
                move_cc.z = (i_src_value[7:0] == 8'h00);
            end
            CMTD_SZ_W: begin
                move_cc.n = i_src_value[15];
                move_cc.z = (i_src_value[15:0] == 16'h0000);
            end
            default: begin
                move_cc.n = i_src_value[31];
                move_cc.z = (i_src_value == 32'h0000_0000);
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_done <= 1'b0;
            o_cc_we <= 1'b0;
            o_cc <= '0;
            o_illegal <= 1'b0;
            o_priv_trap <= 1'b0;
            o_dec <= '0;
        end else begin
            o_done <= (state_q == CMTD_ST_EXEC);
            o_cc_we <= 1'b0;
            o_illegal <= 1'b0;
            o_priv_trap <= 1'b0;
            if (state_q == CMTD_ST_EXEC) begin
                o_dec <= dec_q;
                if (dec_q.illegal) begin
                    o_illegal <= 1'b1;
                end else begin
                    case (dec_q.kind)
                        CMTD_K_CMP, CMTD_K_COMPARE_ADDRESS_REGISTER, CMTD_K_COMPARE_WITH_IMMEDIATE: begin
                            o_cc_we <= 1'b1;
                            o_cc <= sub_cc;
                        end
                        CMTD_K_MOVE: begin
                            o_cc_we <= 1'b1;
                            o_cc <= move_cc;
                        end
                        CMTD_K_TOUCH: o_priv_trap <= !i_supervisor;
                        // touch and address move keep flags
                        default: o_cc_we <= 1'b0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_fill_req <= 1'b0;
            o_fill_addr <= 32'h0000_0000;
            o_fill_bytes <= 5'h00;
        end else begin
            // Set wins over a same-cycle fill done
            if (state_q == CMTD_ST_EXEC && dec_q.kind == CMTD_K_TOUCH &&
                !dec_q.illegal && i_supervisor && i_cacheable) begin
                // cacheable touch fetches a full line
                o_fill_req <= 1'b1;
                o_fill_addr <= i_areg_value;
                o_fill_bytes <= `CMTD_LINE_BYTES;
            end else if (i_fill_done) begin
                o_fill_req <= 1'b0;
            end
        end
    end

    // Opcode latched only when idle; later words are extensions
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dec_q <= '0;
        end else if (state_q == CMTD_ST_IDLE && i_word_valid) begin
            dec_q <= dec_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            imm_q <= 32'h0000_0000;
        end else if (i_word_valid) begin
            if (state_q == CMTD_ST_EXT1) begin
                imm_q <= {16'h0000, i_word};
            end else if (state_q == CMTD_ST_EXT2) begin
                imm_q <= {imm_q[15:0], i_word};
            end
        end
    end

    // Refused words show here, one cycle late
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_q != CMTD_ST_IDLE);
        end
    end

    // line locks once control bit is set
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_fill_lock <= 1'b0;
        end else begin
            o_fill_lock <= i_cache_ctrl[`CMTD_LOCK_BIT];
        end
    end
endmodule : cmtd_decoder
`default_nettype wire

// File: testbench/cmtd_decoder_monitor.sv
/*
 Checker for cmtd_decoder: assertions and covers on its ports.
 Assumes binding into every cmtd_decoder instance, single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cmtd_decoder_monitor (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_supervisor,
    input wire logic [31:0] i_cache_ctrl,
    input wire logic i_fill_done,
    input wire cmtd_pkg::cmtd_dec_t o_dec,
    input wire logic o_done,
    input wire logic o_cc_we,
    input wire cmtd_pkg::cmtd_cc_t o_cc,
    input wire logic o_illegal,
    input wire logic o_priv_trap,
    input wire logic o_fill_req,
    input wire logic [31:0] o_fill_addr,
    input wire logic [4:0] o_fill_bytes,
    input wire logic o_fill_lock
);
    import cmtd_pkg::*;
    default clocking mon_cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_fill_line_size: assert property (o_fill_req |-> o_fill_bytes == 5'h10)
        else $error("fill size is not one line");
    a_fill_held: assert property (o_fill_req && !i_fill_done |=> o_fill_req && $stable(o_fill_addr))
        else $error("fill request dropped or moved early");
    a_fill_ends: assert property (o_fill_req && i_fill_done |-> ##[1:2] !o_fill_req)
        else $error("fill request outlives fill done");
    a_trap_quiet: assert property (o_priv_trap |-> !o_fill_req && !o_cc_we)
        else $error("trapped touch still acted");
    a_trap_user: assert property (o_priv_trap |-> !$past(i_supervisor))
        else $error("trap raised in supervisor state");
    a_lock_follows: assert property (o_fill_req && i_cache_ctrl[11] |=> o_fill_lock)
        else $error("lock bit not followed");
    a_touch_keeps_cc: assert property (o_done && o_dec.kind == CMTD_K_TOUCH |-> !o_cc_we)
        else $error("touch wrote flags");
    a_move_to_address_register_keeps_cc: assert property (o_done && o_dec.kind == CMTD_K_MOVE_TO_ADDRESS_REGISTER |-> !o_cc_we)
        else $error("address move wrote flags");
    a_move_clears_vc: assert property (o_cc_we && o_dec.kind == CMTD_K_MOVE |-> !o_cc.v && !o_cc.c)
        else $error("move left overflow or carry set");
    a_cc_holds: assert property (!o_cc_we |-> $stable(o_cc))
        else $error("flags changed without a write");
    a_illegal_quiet: assert property (o_illegal |-> !o_cc_we && !o_fill_req)
        else $error("illegal encoding still acted");
    a_compare_address_register_no_byte: assert property (o_done && o_dec.kind == CMTD_K_COMPARE_ADDRESS_REGISTER |-> o_dec.size != CMTD_SZ_B)
        else $error("address compare at byte size");

    c_fill_done: cover property (o_fill_req && i_fill_done);
    c_illegal: cover property (o_illegal);
    c_trap: cover property (o_priv_trap);
    c_overflow: cover property (o_cc_we && o_cc.v);
endmodule : cmtd_decoder_monitor

bind cmtd_decoder cmtd_decoder_monitor cmtd_decoder_monitor_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_supervisor(i_supervisor), .i_cache_ctrl(i_cache_ctrl),
    .i_fill_done(i_fill_done), .o_dec(o_dec), .o_done(o_done), .o_cc_we(o_cc_we), .o_cc(o_cc),
    .o_illegal(o_illegal), .o_priv_trap(o_priv_trap), .o_fill_req(o_fill_req),
    .o_fill_addr(o_fill_addr), .o_fill_bytes(o_fill_bytes), .o_fill_lock(o_fill_lock)
);
`default_nettype wire

// File: testbench/cmtd_decoder_bench.sv
/*
 Self-checking bench for cmtd_decoder with a flag model in the bench.
 Assumes the decoder package and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module cmtd_decoder_bench;
    import cmtd_pkg::*;
    logic i_clk, i_srst, i_word_valid, i_supervisor, i_cacheable, i_fill_done;
    logic [15:0] i_word;
    logic [31:0] i_dreg_value, i_areg_value, i_src_value, i_cache_ctrl;
    logic o_busy, o_done, o_cc_we, o_illegal, o_priv_trap, o_fill_req, o_fill_lock;
    cmtd_dec_t o_dec;
    cmtd_cc_t o_cc;
    logic [31:0] o_fill_addr;
    logic [4:0] o_fill_bytes;
    int mismatches, checks;
    integer seed;
    logic [3:0] r_cc;
    logic r_done, r_we, r_ill, r_trap, r_fill;
    logic [16:0] mv_tab [12];

    cmtd_decoder cmtd_decoder_inst (
        .i_clk(i_clk), .i_srst(i_srst), .i_word_valid(i_word_valid), .i_word(i_word),
        .i_supervisor(i_supervisor), .i_dreg_value(i_dreg_value), .i_areg_value(i_areg_value),
        .i_src_value(i_src_value), .i_cacheable(i_cacheable), .i_cache_ctrl(i_cache_ctrl),
        .i_fill_done(i_fill_done), .o_busy(o_busy), .o_dec(o_dec), .o_done(o_done),
        .o_cc_we(o_cc_we), .o_cc(o_cc), .o_illegal(o_illegal), .o_priv_trap(o_priv_trap),
        .o_fill_req(o_fill_req), .o_fill_addr(o_fill_addr), .o_fill_bytes(o_fill_bytes),
        .o_fill_lock(o_fill_lock)
    );

    initial begin
        i_clk = 1'h0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Sized subtract flags N Z V C; borrow taken from the zero-extended difference
    function automatic logic [3:0] sub_cc(input logic [31:0] d, input logic [31:0] s, input int w);
        logic [31:0] m;
        logic [32:0] r;
        m = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
        r = {1'h0, d & m} - {1'h0, s & m};
        return {r[w-1], (r[31:0] & m) == 32'h0, (d[w-1] != s[w-1]) && (r[w-1] != d[w-1]), r[32]};
    endfunction : sub_cc

    function automatic logic [3:0] mv_cc(input logic [31:0] v, input int w);
        logic [31:0] m;
        m = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
        return {v[w-1], (v & m) == 32'h0, 2'h0};
    endfunction : mv_cc

    task automatic setv(input logic [31:0] d, input logic [31:0] s, input logic [31:0] a);
        @(posedge i_clk);
        i_dreg_value <= d;
        i_src_value <= s;
        i_areg_value <= a;
    endtask : setv

    // One opcode plus extension words back to back, then a bounded wait for the result
    task automatic issue(input logic [15:0] op, input int n_ext, input logic [31:0] imm);
        int k;
        @(posedge i_clk);
        i_word_valid <= 1'h1;
        i_word <= op;
        if (n_ext == 2) begin
            @(posedge i_clk);
            i_word <= imm[31:16];
        end
        if (n_ext > 0) begin
            @(posedge i_clk);
            i_word <= imm[15:0];
        end
        @(posedge i_clk);
        i_word_valid <= 1'h0;
        for (k = 0; k < 12; k++) begin
            @(posedge i_clk);
            #1;
            if ((o_done | o_illegal | o_priv_trap | o_fill_req) === 1'h1) break;
        end
        chk({31'h0, k < 12}, 32'h1);
        r_done = o_done;
        r_we = o_cc_we;
        r_cc = o_cc;
        r_ill = o_illegal;
        r_trap = o_priv_trap;
        r_fill = o_fill_req;
    endtask : issue

    initial begin
        repeat (6000) @(posedge i_clk);
        mismatches++;
        test_done();
    end

    initial begin
        int sel, it, w;
        logic [31:0] d, s, a;
        seed = 32'h32925C1C;
        {i_srst, i_word_valid, i_word, i_supervisor, i_cacheable, i_fill_done} = '0;
        {i_dreg_value, i_areg_value, i_src_value, i_cache_ctrl} = '0;
        i_srst = 1'h1;
        mismatches = 0;
        checks = 0;
        mv_tab = '{{1'h0, 4'h1, 3'h0, 3'h0, 3'h0, 3'h1}, {1'h0, 4'h3, 3'h2, 3'h2, 3'h7, 3'h3},
            {1'h1, 4'h2, 3'h1, 3'h5, 3'h7, 3'h4}, {1'h0, 4'h3, 3'h1, 3'h5, 3'h7, 3'h4},
            {1'h1, 4'h1, 3'h0, 3'h6, 3'h5, 3'h2}, {1'h0, 4'h1, 3'h0, 3'h6, 3'h0, 3'h2},
            {1'h1, 4'h2, 3'h0, 3'h7, 3'h7, 3'h2}, {1'h1, 4'h2, 3'h4, 3'h7, 3'h0, 3'h0},
            {1'h1, 4'h3, 3'h2, 3'h7, 3'h0, 3'h0}, {1'h0, 4'h2, 3'h3, 3'h0, 3'h7, 3'h1},
            {1'h0, 4'h2, 3'h1, 3'h7, 3'h3, 3'h4}, {1'h0, 4'h3, 3'h5, 3'h4, 3'h6, 3'h6}};
        repeat (8) @(posedge i_clk);
        i_srst <= 1'h0;
        @(posedge i_clk);
        #1;
        chk({o_busy, o_done, o_cc_we, o_illegal, o_fill_req, o_cc}, 32'h0);
        for (sel = 0; sel < 3; sel++) begin
            w = 8 << sel;
            for (it = 0; it < 4; it++) begin
                d = $random(seed);
                s = (it == 0) ? d : $random(seed);
                if (it == 1) begin
                    d = 32'h1 << (w - 1);
                    s = 32'h1;
                end
                if (it == 2) s = s | 32'h8000;
                setv(d, s, d);
                issue({4'hB, 3'h2, sel[2:0], 3'h0, 3'h5}, 0, 32'h0);
                chk(r_cc, sub_cc(d, s, w));
                chk(r_we, 1'h1);
                if (sel > 0) begin
                    issue({4'hB, 3'h1, (sel == 1) ? 3'h3 : 3'h7, 3'h0, 3'h2}, 0, 32'h0);
                    a = (sel == 1) ? {{16{s[15]}}, s[15:0]} : s;
                    chk(r_cc, sub_cc(d, a, 32));
                end
                issue({8'h0C, sel[1:0], 3'h0, 3'h4}, (sel == 2) ? 2 : 1, s);
                chk(r_cc, sub_cc(d, s, w));
                chk(o_dec.dst_reg, 32'h4);
            end
        end
        issue({4'hB, 3'h0, 3'h0, 3'h1, 3'h1}, 0, 32'h0);
        chk(r_ill, 1'h1);
        issue({4'hB, 3'h0, 3'h1, 3'h1, 3'h1}, 0, 32'h0);
        chk(r_ill, 1'h0);
        issue({4'hB, 3'h0, 3'h3, 3'h1, 3'h1}, 0, 32'h0);
        chk(r_ill, 1'h0);
        issue({4'hB, 3'h0, 3'h4, 3'h0, 3'h1}, 0, 32'h0);
        chk(r_ill, 1'h1);
        for (it = 0; it < 12; it++) begin
            s = (it % 3 == 0) ? 32'hFFFF0000 : $random(seed);
            w = (mv_tab[it][13:12] == 2'h1) ? 8 : (mv_tab[it][13:12] == 2'h3) ? 16 : 32;
            setv(32'h0, s, 32'h0);
            issue(mv_tab[it][15:0], 0, 32'h0);
            chk(r_ill, mv_tab[it][16]);
            if (mv_tab[it][16] === 1'h0) chk(r_cc, mv_cc(s, w));
        end
        for (it = 2; it < 4; it++) begin
            issue({2'h0, it[1:0], 3'h2, 3'h1, 3'h0, 3'h3}, 0, 32'h0);
            chk({r_done, r_we, r_ill}, 32'h4);
            chk(o_dec.kind, CMTD_K_MOVE_TO_ADDRESS_REGISTER);
        end
        a = $random(seed);
        @(posedge i_clk);
        i_supervisor <= 1'h1;
        i_cacheable <= 1'h1;
        setv(32'h0, 32'h0, a);
        issue(16'hF42B, 0, 32'h0);
        chk({r_fill, r_trap, r_we}, 32'h4);
        chk(o_fill_addr, a);
        chk({o_busy, o_fill_bytes}, 6'h30);
        @(posedge i_clk);
        i_fill_done <= 1'h1;
        i_cache_ctrl <= 32'h800;
        @(posedge i_clk);
        i_fill_done <= 1'h0;
        repeat (2) @(posedge i_clk);
        #1;
        chk({o_busy, o_fill_req, o_fill_lock}, 32'h1);
        i_cacheable <= 1'h0;
        issue(16'hF42B, 0, 32'h0);
        chk({r_fill, r_trap, r_we}, 32'h0);
        i_cacheable <= 1'h1;
        i_supervisor <= 1'h0;
        issue(16'hF42B, 0, 32'h0);
        chk({r_fill, r_trap}, 32'h1);
        repeat (4) @(posedge i_clk);
        test_done();
    end
endmodule : cmtd_decoder_bench
`default_nettype wire
